// ==== hdl/mul_file_unit.sv ====
// working-register by file-register multiply datapath
// assumes instruction, operands and file read data arrive on clk;
// the file memory returns read data in the cycle its address is held
`timescale 1ns/100ps
module mul_file_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] working_register,
    input wire logic [3:0] bank_select_register,
    input wire logic [7:0] file_rd_data,
    output logic ready,
    output logic [11:0] file_addr,
    output logic file_rd_en,
    output logic [7:0] product_high_byte,
    output logic [7:0] product_low_byte,
    output logic product_done
);
    import mul_file_pkg::*;

    state_type s_r;
    state_type s_nxt;
    logic [15:0] product;
    logic take;

    // true when the word is this multiply
    function automatic logic is_mult(input logic [15:0] word);
        is_mult = (word[OPCODE_MSB:OPCODE_LSB] == MULT_OPCODE);
    endfunction : is_mult

    // operand address from the a bit, bank register and f
    function automatic logic [11:0] operand_addr(
        input logic [15:0] word,
        input logic [3:0] bank
    );
        logic [7:0] f;
        f = word[FILE_ADDR_MSB:0];
        if (word[ACCESS_SEL_BIT])
            operand_addr = {bank, f};
        else if (f < ACCESS_SPLIT)
            operand_addr = {ACCESS_LOW_BANK, f};
        else
            operand_addr = {ACCESS_HIGH_BANK, f};
    endfunction : operand_addr

    // the full 16-bit product of the held operands
    unsigned_mult #(
        .WIDTH(8)
    ) u_mult (
        .a(s_r.w_op),
        .b(file_rd_data),
        .product(product)
    );

    assign take = instr_valid && s_r.ready && is_mult(instr_word);

    // next state: capture operand, fetch file byte, write product pair
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.file_rd_en = 1'b0;
        case (s_r.phase)
            ST_IDLE:
            begin
                if (take)
                begin
                    s_nxt.phase = ST_FETCH;
                    s_nxt.w_op = working_register;
                    s_nxt.file_addr =
                        operand_addr(instr_word, bank_select_register);
                    s_nxt.file_rd_en = 1'b1;
                    s_nxt.ready = 1'b0;
                end
            end
            ST_FETCH:
            begin
                // only the product pair is written; no flag, no source
                s_nxt.prod_hi = product[15:8];
                s_nxt.prod_lo = product[7:0];
                s_nxt.done = 1'b1;
                s_nxt.ready = 1'b1;
                s_nxt.phase = ST_IDLE;
            end
            default:
            begin
                s_nxt.phase = ST_IDLE;
                s_nxt.ready = 1'b1;
            end
        endcase
    end

    // state register with synchronous reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_r.phase <= ST_IDLE;
            s_r.w_op <= PRODUCT_RESET;
            s_r.file_addr <= ADDR_RESET;
            s_r.file_rd_en <= 1'b0;
            s_r.prod_hi <= PRODUCT_RESET;
            s_r.prod_lo <= PRODUCT_RESET;
            s_r.done <= 1'b0;
            s_r.ready <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops
    assign ready = s_r.ready;
    assign file_addr = s_r.file_addr;
    assign file_rd_en = s_r.file_rd_en;
    assign product_high_byte = s_r.prod_hi;
    assign product_low_byte = s_r.prod_lo;
    assign product_done = s_r.done;

    // checks on decode, addressing and product write
    property p_decode_take;
        @(posedge clk) disable iff (rst)
        take |=> file_rd_en && !ready ##1 product_done && ready;
    endproperty
    a_decode_take: assert property (p_decode_take)
        else $error("multiply not fetched and written in two cycles");

    property p_decode_reject;
        @(posedge clk) disable iff (rst)
        instr_valid && ready && !is_mult(instr_word) |=> !file_rd_en;
    endproperty
    a_decode_reject: assert property (p_decode_reject)
        else $error("non-multiply word started a fetch");

    property p_product_value;
        @(posedge clk) disable iff (rst)
        file_rd_en |=> {product_high_byte, product_low_byte} ==
            16'($past(s_r.w_op)) * 16'($past(file_rd_data));
    endproperty
    a_product_value: assert property (p_product_value)
        else $error("product is not the unsigned byte product");

    property p_high_byte;
        @(posedge clk) disable iff (rst)
        take ##1 file_rd_en ##1 product_done |->
            product_high_byte == 8'((16'($past(working_register, 2)) *
            16'($past(file_rd_data))) >> 8);
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high product byte wrong");

    property p_operand_kept;
        @(posedge clk) disable iff (rst)
        take |=> s_r.w_op == $past(working_register)
            ##1 s_r.w_op == $past(working_register, 2);
    endproperty
    a_operand_kept: assert property (p_operand_kept)
        else $error("captured working operand changed");

    property p_access_bank;
        @(posedge clk) disable iff (rst)
        take && !instr_word[ACCESS_SEL_BIT] |=>
            file_addr[11:8] == ($past(instr_word[7]) ?
            ACCESS_HIGH_BANK : ACCESS_LOW_BANK)
            && file_addr[7:0] == $past(instr_word[7:0]);
    endproperty
    a_access_bank: assert property (p_access_bank)
        else $error("access bank address wrong");

    property p_banked;
        @(posedge clk) disable iff (rst)
        take && instr_word[ACCESS_SEL_BIT] |=>
            file_addr == {$past(bank_select_register),
            $past(instr_word[7:0])};
    endproperty
    a_banked: assert property (p_banked)
        else $error("banked address wrong");

    property p_pair_together;
        @(posedge clk) disable iff (rst)
        $changed(product_high_byte) || $changed(product_low_byte) |->
            product_done && $past(file_rd_en);
    endproperty
    a_pair_together: assert property (p_pair_together)
        else $error("product byte changed outside a write step");

    // low byte is the product of the operands seen at take and fetch
    property p_low_byte;
        @(posedge clk) disable iff (rst)
        take ##1 file_rd_en ##1 product_done |->
            product_low_byte == 8'(16'($past(working_register, 2)) *
            16'($past(file_rd_data)));
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low product byte wrong");

    // operand address only moves when a multiply is taken
    property p_addr_held;
        @(posedge clk) disable iff (rst)
        !take |=> $stable(file_addr);
    endproperty
    a_addr_held: assert property (p_addr_held)
        else $error("operand address moved without a take");

    // the write step is a single-cycle pulse
    property p_done_pulse;
        @(posedge clk) disable iff (rst)
        product_done |=> !product_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("product write step lasted more than one cycle");

    // busy lasts exactly the fetch cycle
    property p_ready_back;
        @(posedge clk) disable iff (rst)
        !ready |=> ready;
    endproperty
    a_ready_back: assert property (p_ready_back)
        else $error("unit stayed busy longer than one cycle");

    c_access: cover property (@(posedge clk) disable iff (rst)
        take && !instr_word[ACCESS_SEL_BIT] ##2 product_done);
    c_banked: cover property (@(posedge clk) disable iff (rst)
        take && instr_word[ACCESS_SEL_BIT] ##2 product_done);
    c_max_product: cover property (@(posedge clk) disable iff (rst)
        product_done && {product_high_byte, product_low_byte} == 16'hFE01);
    c_back_to_back: cover property (@(posedge clk) disable iff (rst)
        product_done && take);
endmodule : mul_file_unit

// ==== hdl/mul_file_pkg.sv ====
// constants and types for the working-register by file-register multiply
// assumes one core clock and a synchronous active-high core reset
// What this block does
// - decode opcode 0000001a ffffffff, f 0..255
// - multiply working and file bytes unsigned
// - high byte and low byte of product
// - working and file registers stay untouched
// - no status flag changes at all
// - no overflow, carry or zero flag
// - a=0 selects access bank, ignores bank
// - a=1 uses bank select register with f
package mul_file_pkg;
    localparam int OPCODE_MSB = 15;
    localparam int OPCODE_LSB = 9;
    localparam logic [6:0] MULT_OPCODE = 7'h01;
    localparam int ACCESS_SEL_BIT = 8;
    localparam int FILE_ADDR_MSB = 7;
    // access bank split: low part of bank low, upper part of bank high
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [7:0] PRODUCT_RESET = 8'h00;
    localparam logic [11:0] ADDR_RESET = 12'h000;

    // gray-coded sequence: idle then operand fetch
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_FETCH = 1'b1
    } phase_type;

    typedef struct packed {
        phase_type phase;
        logic [7:0] w_op;
        logic [11:0] file_addr;
        logic file_rd_en;
        logic [7:0] prod_hi;
        logic [7:0] prod_lo;
        logic done;
        logic ready;
    } state_type;
endpackage : mul_file_pkg

// ==== hdl/unsigned_mult.sv ====
// combinational unsigned multiplier, full-width product
// assumes operands are settled within the calling clock period
`timescale 1ns/100ps
module unsigned_mult #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    output logic [2*WIDTH-1:0] product
);
    // zero-extend both sides so the product never loses a carry
    always_comb
    begin
        product = {{WIDTH{1'b0}}, a} * {{WIDTH{1'b0}}, b};
    end
endmodule : unsigned_mult

// ==== verification/register_multiply_instruction_tb.sv ====
// self-checking bench for the working-register by file-register multiply
// assumes mul_file_pkg and mul_file_unit are compiled first
`timescale 1ns/100ps
module register_multiply_instruction_tb;
    import mul_file_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] working_register = 8'h00;
    logic [3:0] bank_select_register = 4'h0;
    logic [7:0] file_rd_data = 8'h00;
    logic ready;
    logic file_rd_en;
    logic product_done;
    logic [11:0] file_addr;
    logic [7:0] prod_hi;
    logic [7:0] prod_lo;
    logic [15:0] last_prod = 16'h0000;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;

    mul_file_unit i_dut (
        .clk(clk),
        .rst(rst),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .working_register(working_register),
        .bank_select_register(bank_select_register),
        .file_rd_data(file_rd_data),
        .ready(ready),
        .file_addr(file_addr),
        .file_rd_en(file_rd_en),
        .product_high_byte(prod_hi),
        .product_low_byte(prod_lo),
        .product_done(product_done)
    );

    // clock generator and hang guard
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // operand address the access-bit selection should produce
    function automatic logic [11:0] exp_addr(input logic a,
        input logic [7:0] f, input logic [3:0] b);
        if (a)
            return {b, f};
        return {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    endfunction : exp_addr

    // one multiply; busy cycle scrambles operands and offers an ignored word
    task automatic mul(input logic a, input logic [7:0] f,
        input logic [7:0] w, input logic [3:0] b, input logic [7:0] d);
        logic [15:0] p;
        p = 16'(w) * 16'(d);
        instr_valid = 1'b1;
        instr_word = {MULT_OPCODE, a, f};
        working_register = w;
        bank_select_register = b;
        @(posedge clk);
        #1;
        check("file_rd_en", 16'(file_rd_en), 16'h0001);
        check("ready", 16'(ready), 16'h0000);
        check("file_addr", 16'(file_addr),
            16'(exp_addr(a, f, b)));
        check("product early", {prod_hi, prod_lo}, last_prod);
        file_rd_data = d;
        working_register = ~w;
        bank_select_register = ~b;
        instr_word = {MULT_OPCODE, ~a, ~f};
        @(posedge clk);
        #1;
        file_rd_data = ~d;
        check("product_done", 16'(product_done), 16'h0001);
        check("busy take", 16'(file_rd_en), 16'h0000);
        check("ready again", 16'(ready), 16'h0001);
        check("product", {prod_hi, prod_lo}, p);
        last_prod = p;
    endtask : mul

    initial
    begin
        void'($urandom(32'h56de_522d));
        repeat (6) @(posedge clk);
        #1;
        rst = 1'b0;
        check("reset product", {prod_hi, prod_lo}, 16'h0000);
        check("reset addr", 16'(file_addr), 16'h0000);
        check("reset rdy", 16'({ready, file_rd_en, product_done}),
            16'h0004);
        $display("reset test done");
        // corner cases, back to back
        mul(1'b0, 8'h7F, 8'h02, 4'h5, 8'h03);
        mul(1'b0, 8'h80, 8'hFF, 4'h5, 8'hFF);
        mul(1'b1, 8'h80, 8'h00, 4'h0, 8'hA5);
        mul(1'b1, 8'hFF, 8'hC4, 4'hF, 8'hB5);
        mul(1'b0, 8'h00, 8'h01, 4'hA, 8'h00);
        $display("corner test done");
        repeat (200)
            mul(1'($urandom), 8'($urandom), 8'($urandom), 4'($urandom),
                8'($urandom));
        $display("random test done");
        // other opcodes and an invalid multiply are ignored
        for (int op = 0; op < 129; op++)
        begin
            // the multiply opcode itself is skipped without driving
            if (op == 1)
                continue;
            instr_valid = (op != 128);
            instr_word = {(op == 128) ? MULT_OPCODE : 7'(op), 9'($urandom)};
            @(posedge clk);
            #1;
            check("refused", 16'(file_rd_en), 16'h0000);
            check("kept", {prod_hi, prod_lo}, last_prod);
        end
        $display("refusal test done");
        final_report();
    end
endmodule : register_multiply_instruction_tb
